// ==== include/bstm_map.svh ====
`ifndef BSTM_MAP_SVH
`define BSTM_MAP_SVH

// Register byte offsets
`define BSTM_OFF_STATE     8'h00
`define BSTM_OFF_RATE      8'h04
`define BSTM_OFF_REMCAP    8'h08
`define BSTM_OFF_VOLT      8'h0C
`define BSTM_OFF_TRIP      8'h10
`define BSTM_OFF_EVENT     8'h14
`define BSTM_OFF_SOURCE    8'h18
`define BSTM_OFF_UNIT      8'h1C
`define BSTM_OFF_DCAP      8'h20
`define BSTM_OFF_LFCAP     8'h24
`define BSTM_OFF_TECH      8'h28
`define BSTM_OFF_DVOLT     8'h2C
`define BSTM_OFF_WARN      8'h30
`define BSTM_OFF_LOW       8'h34
`define BSTM_OFF_GRAN1     8'h38
`define BSTM_OFF_GRAN2     8'h3C
`define BSTM_OFF_STR_IDX   8'h40
`define BSTM_OFF_STR_DATA  8'h44

// State word bit positions
`define BSTM_BIT_DISCHG    0
`define BSTM_BIT_CHG       1
`define BSTM_BIT_CRIT      2

// Event register bits
`define BSTM_EV_STATE      0
`define BSTM_EV_TRIP       1

// Values
`define BSTM_UNKNOWN       32'hFFFFFFFF
`define BSTM_MAX_VAL       32'h7FFFFFFF
`define BSTM_THR_MAX       32'h07FFFFFF
`define BSTM_TECH_PRIMARY  32'h00000000
`define BSTM_TECH_SECOND   32'h00000001
`define BSTM_UNIT_MW       32'h00000000
`define BSTM_UNIT_MA       32'h00000001
`define BSTM_TRIP_RST      32'h00000000
`define BSTM_STR_BYTES     64
`define BSTM_NUL           8'h00

`endif

// ==== include/bstm_pkg.sv ====
package bstm_pkg;

    typedef struct packed {
        logic        critical;
        logic        charging;
        logic        discharging;
        logic [31:0] rate;
        logic [31:0] remcap;
        logic [31:0] volt;
    } bstm_status_s;

    typedef struct packed {
        logic [31:0] unit;
        logic [31:0] dcap;
        logic [31:0] lfcap;
        logic [31:0] tech;
        logic [31:0] dvolt;
        logic [31:0] warn;
        logic [31:0] low;
        logic [31:0] gran1;
        logic [31:0] gran2;
    } bstm_info_s;

    typedef enum logic [1:0] {
        BSTM_STR_MODEL,
        BSTM_STR_SERIAL,
        BSTM_STR_TYPE,
        BSTM_STR_VENDOR
    } bstm_str_e;

endpackage

// ==== rtl/bstm_str_rom.sv ====
`include "bstm_map.svh"

module bstm_str_rom (
    // Selection
    input wire logic [5:0] idx_i,
    input wire logic vendor_en_i,
    // Result
    output logic [7:0] char_o
);
    logic [7:0] text [0:63];
    logic [7:0] raw;

    // Four fixed zero-terminated ASCII strings, 16 bytes each
    assign text = '{
        8'h42, 8'h41, 8'h54, 8'h2D, 8'h4D, 8'h4F, 8'h44, 8'h45,
        8'h4C, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h53, 8'h4E, 8'h30, 8'h30, 8'h30, 8'h31, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h4C, 8'h49, 8'h4F, 8'h4E, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h56, 8'h49, 8'h4E, 8'h46, 8'h4F, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00
    };
    assign raw = text[idx_i];
    // Unsupported vendor string reads as 16 zero bytes
    assign char_o = (idx_i[5:4] == 2'h3 && !vendor_en_i) ? `BSTM_NUL : raw;
endmodule // bstm_str_rom

// ==== rtl/bstm_monitor.sv ====
`include "bstm_map.svh"

module bstm_monitor (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Gauge inputs
    input wire bstm_pkg::bstm_status_s gauge_i,
    input wire bstm_pkg::bstm_info_s info_i,
    input wire logic ac_online_i,
    input wire logic vendor_en_i,
    // Interrupt
    output logic system_control_interrupt_o
);
    bstm_pkg::bstm_status_s st_reg;
    bstm_pkg::bstm_info_s inf_reg;
    logic [2:0] state_next;
    logic [31:0] rate_next;
    logic [31:0] remcap_next;
    logic [31:0] volt_next;
    logic [31:0] trip_reg;
    logic [1:0] event_reg;
    logic [1:0] event_next;
    logic [5:0] str_idx_reg;
    logic [7:0] str_char;
    logic ac_reg;
    logic [31:0] ack_data;
    logic ack_reg;
    logic sci_reg;
    logic state_seen_reg;
    logic rechargeable;
    logic state_change;
    logic trip_armed_reg;
    logic trip_hit;
    logic req;
    logic wr;
    logic rd_data_sel_ok;
    logic [31:0] rd_mux;
    logic [31:0] wr_merge_trip;
    logic [31:0] wr_merge_event;

    function automatic logic [31:0] clamp_val(input logic [31:0] v, input logic [31:0] lim,
                                              input logic force_valid);
        if (v == `BSTM_UNKNOWN && !force_valid)
            clamp_val = `BSTM_UNKNOWN;
        else if (v > lim)
            clamp_val = lim;
        else
            clamp_val = v;
    endfunction

    function automatic logic [31:0] merge_bytes(input logic [31:0] old, input logic [31:0] nw,
                                                input logic [3:0] sel);
        for (int i = 0; i < 4; i++)
            merge_bytes[i*8 +: 8] = sel[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
    endfunction

    assign rechargeable = info_i.tech[0];
    assign req = wb_cyc_i && wb_stb_i && !ack_reg;
    assign wr = req && wb_we_i;

    // Charge wins over discharge; critical kept beside either
    assign state_next[`BSTM_BIT_CHG] = gauge_i.charging;
    assign state_next[`BSTM_BIT_DISCHG] = gauge_i.discharging && !gauge_i.charging;
    assign state_next[`BSTM_BIT_CRIT] = gauge_i.critical;

    // Rechargeable battery never shows unknown capacity or voltage, nor unknown rate while discharging
    assign rate_next = clamp_val(gauge_i.rate, `BSTM_MAX_VAL,
                                 rechargeable && state_next[`BSTM_BIT_DISCHG]);
    assign remcap_next = clamp_val(gauge_i.remcap, `BSTM_MAX_VAL, rechargeable);
    assign volt_next = clamp_val(gauge_i.volt, `BSTM_MAX_VAL, rechargeable);

    assign state_change = state_seen_reg &&
                          (state_next != {st_reg.critical, st_reg.charging, st_reg.discharging});
    assign trip_hit = trip_armed_reg && (trip_reg != `BSTM_TRIP_RST) &&
                      (st_reg.remcap != `BSTM_UNKNOWN) && (st_reg.remcap <= trip_reg);

    assign wr_merge_trip = merge_bytes(trip_reg, wb_dat_i, wb_sel_i);
    assign wr_merge_event = merge_bytes({30'h0, event_reg}, wb_dat_i, wb_sel_i);

    // Set wins over write-one-to-clear
    assign event_next[`BSTM_EV_STATE] = state_change ||
        (event_reg[`BSTM_EV_STATE] &&
         !(wr && wb_adr_i == `BSTM_OFF_EVENT && wr_merge_event[`BSTM_EV_STATE] &&
           wb_sel_i[0]));
    assign event_next[`BSTM_EV_TRIP] = trip_hit ||
        (event_reg[`BSTM_EV_TRIP] &&
         !(wr && wb_adr_i == `BSTM_OFF_EVENT && wr_merge_event[`BSTM_EV_TRIP] &&
           wb_sel_i[0]));

    // Read decode, no side effects
    always_comb begin
        rd_data_sel_ok = 1'b1;
        unique case (wb_adr_i)
            `BSTM_OFF_STATE: rd_mux = {29'h0, st_reg.critical, st_reg.charging,
                                      st_reg.discharging};
            `BSTM_OFF_RATE: rd_mux = st_reg.rate;
            `BSTM_OFF_REMCAP: rd_mux = st_reg.remcap;
            `BSTM_OFF_VOLT: rd_mux = st_reg.volt;
            `BSTM_OFF_TRIP: rd_mux = trip_reg;
            `BSTM_OFF_EVENT: rd_mux = {30'h0, event_reg};
            `BSTM_OFF_SOURCE: rd_mux = {31'h0, ac_reg};
            `BSTM_OFF_UNIT: rd_mux = inf_reg.unit;
            `BSTM_OFF_DCAP: rd_mux = inf_reg.dcap;
            `BSTM_OFF_LFCAP: rd_mux = inf_reg.lfcap;
            `BSTM_OFF_TECH: rd_mux = inf_reg.tech;
            `BSTM_OFF_DVOLT: rd_mux = inf_reg.dvolt;
            `BSTM_OFF_WARN: rd_mux = inf_reg.warn;
            `BSTM_OFF_LOW: rd_mux = inf_reg.low;
            `BSTM_OFF_GRAN1: rd_mux = inf_reg.gran1;
            `BSTM_OFF_GRAN2: rd_mux = inf_reg.gran2;
            `BSTM_OFF_STR_IDX: rd_mux = {26'h0, str_idx_reg};
            `BSTM_OFF_STR_DATA: rd_mux = {24'h0, str_char};
            default: begin
                rd_mux = 32'h00000000;
                rd_data_sel_ok = 1'b0;
            end
        endcase
    end
    assign ack_data = rd_data_sel_ok ? rd_mux : 32'h00000000;

    bstm_str_rom u_str (
        .idx_i(str_idx_reg),
        .vendor_en_i(vendor_en_i),
        .char_o(str_char)
    );

    // Status sampling
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_reg <= '0;
            state_seen_reg <= 1'b0;
            ac_reg <= 1'b0;
        end else begin
            st_reg <= {state_next, rate_next, remcap_next, volt_next};
            state_seen_reg <= 1'b1;
            ac_reg <= ac_online_i;
        end
    end

    // Static information, codes forced to their legal values
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            inf_reg <= '0;
        end else begin
            inf_reg.unit <= info_i.unit[0] ? `BSTM_UNIT_MA : `BSTM_UNIT_MW;
            inf_reg.dcap <= info_i.dcap;
            inf_reg.lfcap <= info_i.lfcap;
            inf_reg.tech <= info_i.tech[0] ? `BSTM_TECH_SECOND : `BSTM_TECH_PRIMARY;
            inf_reg.dvolt <= info_i.dvolt;
            inf_reg.warn <= clamp_val(info_i.warn, `BSTM_THR_MAX, 1'b1);
            inf_reg.low <= clamp_val(info_i.low, `BSTM_THR_MAX, 1'b1);
            inf_reg.gran1 <= info_i.gran1;
            inf_reg.gran2 <= info_i.gran2;
        end
    end

    // Trip level; rearmed on every nonzero write, disarmed by a zero write or once it fires
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            trip_reg <= `BSTM_TRIP_RST;
            trip_armed_reg <= 1'b0;
        end else if (wr && wb_adr_i == `BSTM_OFF_TRIP) begin
            trip_reg <= (wr_merge_trip > `BSTM_MAX_VAL) ? `BSTM_MAX_VAL : wr_merge_trip;
            trip_armed_reg <= (wr_merge_trip != `BSTM_TRIP_RST);
        end else if (trip_hit) begin
            trip_armed_reg <= 1'b0;
        end
    end

    // Events and interrupt line
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            event_reg <= 2'h0;
            sci_reg <= 1'b0;
        end else begin
            event_reg <= event_next;
            sci_reg <= |event_next;
        end
    end

    // String index
    always_ff @(posedge clk_i) begin
        if (rst_i)
            str_idx_reg <= 6'h00;
        else if (wr && wb_adr_i == `BSTM_OFF_STR_IDX && wb_sel_i[0])
            str_idx_reg <= wb_dat_i[5:0];
    end

    // Bus answer one cycle after request
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            ack_reg <= req;
            wb_dat_o <= (req && !wb_we_i) ? ack_data : 32'h00000000;
        end
    end

    assign wb_ack_o = ack_reg;
    assign system_control_interrupt_o = sci_reg;

    sequence chg_cyc;
        st_reg.charging;
    endsequence

    sequence bus_quiet;
        !wb_ack_o ##0 (wb_dat_o == 32'h00000000);
    endsequence

    never_both_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !(st_reg.charging && st_reg.discharging))
        else $error("charge and discharge set together");

    state_irq_a: assert property (@(posedge clk_i) disable iff (rst_i)
        state_change |=> event_reg[`BSTM_EV_STATE] ##0 system_control_interrupt_o)
        else $error("state change gave no interrupt");

    trip_irq_a: assert property (@(posedge clk_i) disable iff (rst_i)
        trip_hit |=> event_reg[`BSTM_EV_TRIP])
        else $error("trip crossing gave no event");

    trip_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (wr && wb_adr_i == `BSTM_OFF_TRIP && wr_merge_trip == 32'h0) |=> !trip_armed_reg)
        else $error("zero trip left armed");

    trip_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !(wr && wb_adr_i == `BSTM_OFF_TRIP) |=> $stable(trip_reg))
        else $error("trip level changed without write");

    rate_valid_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (st_reg.discharging && inf_reg.tech[0] && rechargeable) |->
        st_reg.rate != `BSTM_UNKNOWN)
        else $error("unknown rate while discharging");

    cap_valid_a: assert property (@(posedge clk_i) disable iff (rst_i)
        $past(rechargeable) |-> st_reg.remcap <= `BSTM_MAX_VAL)
        else $error("rechargeable capacity invalid");

    volt_valid_a: assert property (@(posedge clk_i) disable iff (rst_i)
        $past(rechargeable) |-> st_reg.volt != `BSTM_UNKNOWN)
        else $error("rechargeable voltage unknown");

    crit_keep_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (gauge_i.critical && gauge_i.charging) |=> chg_cyc ##0 st_reg.critical)
        else $error("charge bit lost while critical");

    bus_ack_a: assert property (@(posedge clk_i) disable iff (rst_i)
        req |=> wb_ack_o ##1 !wb_ack_o)
        else $error("ack not one cycle");

    tech_code_a: assert property (@(posedge clk_i) disable iff (rst_i)
        inf_reg.tech == `BSTM_TECH_PRIMARY || inf_reg.tech == `BSTM_TECH_SECOND)
        else $error("technology code out of range");

    unit_code_a: assert property (@(posedge clk_i) disable iff (rst_i)
        inf_reg.unit == `BSTM_UNIT_MW || inf_reg.unit == `BSTM_UNIT_MA)
        else $error("power unit code out of range");

    state_copy_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !$past(rst_i) |-> {st_reg.critical, st_reg.charging} ==
        {$past(gauge_i.critical), $past(gauge_i.charging)})
        else $error("state word does not follow gauge");

    rate_range_a: assert property (@(posedge clk_i) disable iff (rst_i)
        st_reg.rate <= `BSTM_MAX_VAL || st_reg.rate == `BSTM_UNKNOWN)
        else $error("rate out of range");

    remcap_range_a: assert property (@(posedge clk_i) disable iff (rst_i)
        st_reg.remcap <= `BSTM_MAX_VAL || st_reg.remcap == `BSTM_UNKNOWN)
        else $error("capacity out of range");

    thr_range_a: assert property (@(posedge clk_i) disable iff (rst_i)
        inf_reg.warn <= `BSTM_THR_MAX && inf_reg.low <= `BSTM_THR_MAX)
        else $error("threshold out of range");

    trip_range_a: assert property (@(posedge clk_i) disable iff (rst_i)
        trip_reg <= `BSTM_MAX_VAL)
        else $error("trip level out of range");

    source_copy_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !$past(rst_i) |-> ac_reg == $past(ac_online_i))
        else $error("power source does not follow input");

    vendor_nul_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (str_idx_reg[5:4] == 2'h3 && !vendor_en_i) |-> str_char == `BSTM_NUL)
        else $error("unsupported vendor string not zero");

    bus_data_a: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_ack_o |=> bus_quiet)
        else $error("bus answer longer than one cycle");

    data_idle_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !wb_ack_o |-> wb_dat_o == 32'h00000000)
        else $error("read data shown without ack");
endmodule // bstm_monitor

// ==== dv/bstm_gauge_model.sv ====
module bstm_gauge_model (
    // Clock
    input wire logic clk_i,
    // Battery side
    output bstm_pkg::bstm_status_s gauge_o,
    output bstm_pkg::bstm_info_s info_o,
    output logic ac_online_o,
    output logic vendor_en_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // Idle battery until told otherwise
    initial begin
        gauge_o = '0;
        info_o = '0;
        ac_online_o = 1'h0;
        vendor_en_o = 1'h0;
    end

    // Readings change just after an edge
    task automatic set_status(input bstm_pkg::bstm_status_s s);
        @(posedge clk_i);
        gauge_o <= s;
    endtask

    task automatic set_info(input bstm_pkg::bstm_info_s i);
        @(posedge clk_i);
        info_o <= i;
    endtask

    task automatic set_misc(input logic ac, input logic ven);
        @(posedge clk_i);
        ac_online_o <= ac;
        vendor_en_o <= ven;
    endtask
endmodule // bstm_gauge_model

// ==== dv/bstm_monitor_bench.sv ====
`include "bstm_map.svh"

module bstm_monitor_bench;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk_i;
    logic rst_i;
    logic wb_cyc_i;
    logic wb_stb_i;
    logic wb_we_i;
    logic [7:0] wb_adr_i;
    logic [3:0] wb_sel_i;
    logic [31:0] wb_dat_i;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic irq;
    bstm_pkg::bstm_status_s gauge;
    bstm_pkg::bstm_info_s info;
    logic ac_online;
    logic vendor_en;
    logic [31:0] rd;
    int n_fail;
    int comparisons;

    bstm_gauge_model i_bstm_gauge_model (
        .clk_i(clk_i),
        .gauge_o(gauge),
        .info_o(info),
        .ac_online_o(ac_online),
        .vendor_en_o(vendor_en)
    );

    bstm_monitor i_bstm_monitor (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o),
        .gauge_i(gauge),
        .info_i(info),
        .ac_online_i(ac_online),
        .vendor_en_i(vendor_en),
        .system_control_interrupt_o(irq)
    );

    initial begin
        clk_i = 1'h0;
        forever #2.5 clk_i = ~clk_i;
    end

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // Classic single cycle, held until ack is sampled
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] sel = 4'hF);
        int k;
        @(posedge clk_i);
        wb_cyc_i <= 1'h1;
        wb_stb_i <= 1'h1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        wb_sel_i <= sel;
        for (k = 0; k < 16 && wb_ack_o !== 1'h1; k++) begin
            @(posedge clk_i);
        end
        if (wb_ack_o !== 1'h1) begin
            n_fail++;
            $display("unexpected ack expected 1 seen %b", wb_ack_o);
            print_verdict();
        end
        rd = wb_dat_o;
        wb_cyc_i <= 1'h0;
        wb_stb_i <= 1'h0;
        wb_we_i <= 1'h0;
    endtask

    task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] exp);
        wb(1'h0, a, 32'h0);
        chk(nm, exp, rd);
    endtask

    task automatic gs(input logic c, g, d, input logic [31:0] r, m, u);
        i_bstm_gauge_model.set_status('{c, g, d, r, m, u});
        repeat (4) @(posedge clk_i);
    endtask

    task automatic si(input bstm_pkg::bstm_info_s v);
        i_bstm_gauge_model.set_info(v);
        repeat (3) @(posedge clk_i);
    endtask

    task automatic t_reset();
        rc("trip", `BSTM_OFF_TRIP, 32'h0);
        rc("event", `BSTM_OFF_EVENT, 32'h0);
        chk("interrupt", 32'h0, {31'h0, irq});
        rc("unmapped", 8'h80, 32'h0);
        $display("reset test done");
    endtask

    task automatic t_info();
        for (int i = 0; i < 2; i++) begin
            si('{32'(i), 32'h1000, 32'hF00, 32'(i), 32'h2EE0, 32'h8000000, 32'h100, 32'h10,
                32'h10});
            rc("unit", `BSTM_OFF_UNIT, 32'(i));
            rc("technology", `BSTM_OFF_TECH, 32'(i));
            rc("warning", `BSTM_OFF_WARN, 32'h7FFFFFF);
            rc("low", `BSTM_OFF_LOW, 32'h100);
            rc("granularity1", `BSTM_OFF_GRAN1, 32'h10);
            rc("granularity2", `BSTM_OFF_GRAN2, 32'h10);
            rc("design capacity", `BSTM_OFF_DCAP, 32'h1000);
            rc("full capacity", `BSTM_OFF_LFCAP, 32'hF00);
            rc("design voltage", `BSTM_OFF_DVOLT, 32'h2EE0);
        end
        $display("info test done");
    endtask

    task automatic t_state();
        gs(1'h0, 1'h0, 1'h1, 32'h500, 32'h800, 32'h2EE0);
        rc("state", `BSTM_OFF_STATE, 32'h1);
        chk("interrupt", 32'h1, {31'h0, irq});
        rc("event", `BSTM_OFF_EVENT, 32'h1);
        rc("event again", `BSTM_OFF_EVENT, 32'h1);
        wb(1'h1, `BSTM_OFF_EVENT, 32'h1);
        repeat (2) @(posedge clk_i);
        chk("interrupt", 32'h0, {31'h0, irq});
        gs(1'h0, 1'h1, 1'h1, 32'h500, 32'h800, 32'h2EE0);
        rc("state", `BSTM_OFF_STATE, 32'h2);
        gs(1'h1, 1'h0, 1'h1, 32'h500, 32'h800, 32'h2EE0);
        rc("state", `BSTM_OFF_STATE, 32'h5);
        gs(1'h1, 1'h1, 1'h0, 32'h500, 32'h800, 32'h2EE0);
        rc("state", `BSTM_OFF_STATE, 32'h6);
        rc("event", `BSTM_OFF_EVENT, 32'h1);
        wb(1'h1, `BSTM_OFF_EVENT, 32'h3);
        $display("state test done");
    endtask

    task automatic t_values();
        bstm_pkg::bstm_info_s v;
        gs(1'h0, 1'h0, 1'h1, 32'hFFFFFFFF, 32'hFFFFFFFF, 32'h80000000);
        rc("rate", `BSTM_OFF_RATE, 32'h7FFFFFFF);
        rc("capacity", `BSTM_OFF_REMCAP, 32'h7FFFFFFF);
        rc("voltage", `BSTM_OFF_VOLT, 32'h7FFFFFFF);
        gs(1'h0, 1'h0, 1'h1, 32'h80000001, 32'h300, 32'hFFFFFFFF);
        rc("rate", `BSTM_OFF_RATE, 32'h7FFFFFFF);
        rc("capacity", `BSTM_OFF_REMCAP, 32'h300);
        rc("voltage", `BSTM_OFF_VOLT, 32'h7FFFFFFF);
        v = info;
        v.tech = 32'h0;
        si(v);
        gs(1'h0, 1'h1, 1'h0, 32'hFFFFFFFF, 32'hFFFFFFFF, 32'hFFFFFFFF);
        rc("rate", `BSTM_OFF_RATE, 32'hFFFFFFFF);
        rc("capacity", `BSTM_OFF_REMCAP, 32'hFFFFFFFF);
        rc("voltage", `BSTM_OFF_VOLT, 32'hFFFFFFFF);
        v.tech = 32'h1;
        si(v);
        $display("values test done");
    endtask

    task automatic t_trip();
        gs(1'h0, 1'h0, 1'h1, 32'h500, 32'h200, 32'h2EE0);
        wb(1'h1, `BSTM_OFF_EVENT, 32'h3);
        wb(1'h1, `BSTM_OFF_TRIP, 32'h100);
        rc("trip", `BSTM_OFF_TRIP, 32'h100);
        gs(1'h0, 1'h0, 1'h1, 32'h500, 32'h101, 32'h2EE0);
        rc("event", `BSTM_OFF_EVENT, 32'h0);
        gs(1'h0, 1'h0, 1'h1, 32'h500, 32'h100, 32'h2EE0);
        rc("event", `BSTM_OFF_EVENT, 32'h2);
        chk("interrupt", 32'h1, {31'h0, irq});
        wb(1'h1, `BSTM_OFF_EVENT, 32'h2);
        gs(1'h0, 1'h0, 1'h1, 32'h500, 32'hFF, 32'h2EE0);
        rc("event", `BSTM_OFF_EVENT, 32'h0);
        rc("trip", `BSTM_OFF_TRIP, 32'h100);
        wb(1'h1, `BSTM_OFF_TRIP, 32'h0);
        rc("trip", `BSTM_OFF_TRIP, 32'h0);
        gs(1'h0, 1'h0, 1'h1, 32'h500, 32'h50, 32'h2EE0);
        rc("event", `BSTM_OFF_EVENT, 32'h0);
        rc("capacity", `BSTM_OFF_REMCAP, 32'h50);
        wb(1'h1, `BSTM_OFF_TRIP, 32'hFFFFFFFF, 4'h1);
        rc("trip", `BSTM_OFF_TRIP, 32'hFF);
        rc("event", `BSTM_OFF_EVENT, 32'h2);
        wb(1'h1, `BSTM_OFF_TRIP, 32'hFFFFFFFF);
        rc("trip", `BSTM_OFF_TRIP, 32'h7FFFFFFF);
        wb(1'h1, `BSTM_OFF_EVENT, 32'h2);
        $display("trip test done");
    endtask

    task automatic t_misc();
        int found;
        i_bstm_gauge_model.set_misc(1'h1, 1'h0);
        rc("source", `BSTM_OFF_SOURCE, 32'h1);
        wb(1'h1, `BSTM_OFF_STR_IDX, 32'h30);
        rc("vendor string", `BSTM_OFF_STR_DATA, 32'h0);
        i_bstm_gauge_model.set_misc(1'h0, 1'h1);
        rc("source", `BSTM_OFF_SOURCE, 32'h0);
        for (int s = 0; s < 4; s++) begin
            found = 0;
            for (int b = 0; b < 16; b++) begin
                wb(1'h1, `BSTM_OFF_STR_IDX, 32'(s * 16 + b));
                wb(1'h0, `BSTM_OFF_STR_DATA, 32'h0);
                if (rd[7:0] === 8'h00) begin
                    found = 1;
                end
            end
            chk("terminator", 32'h1, 32'(found));
        end
        $display("misc test done");
    endtask

    initial begin
        rst_i = 1'h1;
        wb_cyc_i = 1'h0;
        wb_stb_i = 1'h0;
        wb_we_i = 1'h0;
        wb_adr_i = 8'h00;
        wb_sel_i = 4'hF;
        wb_dat_i = 32'h0;
        n_fail = 0;
        comparisons = 0;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'h0;
        repeat (2) @(posedge clk_i);
        t_reset();
        t_info();
        t_state();
        t_values();
        t_trip();
        t_misc();
        print_verdict();
    end
endmodule // bstm_monitor_bench
